/* rtl/bms_pkg.sv */
// Purpose: Shared constants and types for the boot mode select block
// Assumes: 16-bit CPU address space, 8-bit data
// Notes:   Boot ROM sits at the top of the alternate vector page
package bms_pkg;

  // Address and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Boot ROM size and placement
  localparam int                ROM_BYTES    = 192;
  localparam logic [ADDR_W-1:0] ROM_BASE     = 16'hBF40;
  localparam logic [ADDR_W-1:0] ROM_LAST     = 16'hBFFF;

  // Reset vector location and the loader entry point it names
  localparam logic [ADDR_W-1:0] RST_VEC_ADDR = 16'hFFFE;
  localparam logic [ADDR_W-1:0] LOADER_ENTRY = 16'hBF40;
  localparam int                VEC_HI_IDX   = 190;
  localparam int                VEC_LO_IDX   = 191;
  localparam logic [DATA_W-1:0] ROM_FILL     = 8'h01;
  localparam logic [DATA_W-1:0] DATA_IDLE    = 8'h00;

  // Address bit forced low on vector fetches in special modes
  localparam int VEC_FORCE_BIT = 14;

  // Reset values of the mode control bits
  localparam logic BOOT_EN_RST      = 1'b0;
  localparam logic SPECIAL_SEL_RST  = 1'b0;
  localparam logic EXPANDED_SEL_RST = 1'b0;

  // Mode control bits of the priority and mode register
  typedef struct packed {
    logic boot_rom_enable;
    logic special_mode_select;
    logic expanded_mode_select;
  } bms_mode_bits_t;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL_SINGLE,
    MODE_NORMAL_EXPANDED,
    MODE_SPECIAL_BOOT,
    MODE_SPECIAL_TEST
  } bms_mode_t;

  // CPU address request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              vector_fetch;
  } bms_addr_req_t;

endpackage

/* rtl/bms_core.sv */
// Purpose: Operating mode latch, boot ROM enable and vector remap logic
// Assumes: Mode pins synchronous to core_clk; one software write port
// Notes:   Mode pins are caught on the first clock edge after reset release
//
// Functional notes
// RL1: Boot ROM appears in the map only while boot ROM enable is 1.
// RL2: Software may write boot ROM enable in special test or special bootstrap.
// RL3: In normal modes boot ROM enable is forced 0 and software writes ignored.
// RL4: Expanded-mode select loads from mode pin A as reset ends.
// RL5: Expanded-mode select 0 gives a single-chip mode, 1 an expanded mode.
// RL6: Special-mode select loads the inverse of mode pin B as reset ends.
// RL7: Special-mode select 0 gives a normal mode, 1 a special mode.
// RL8: Special modes allow mode bit writes and vectors from the BFxx page.
// RL9: Address bit 14 is forced low on vector fetches while special-mode is 1.
// RL10: Reset sets boot ROM enable only in special bootstrap mode.
// RL11: Bootstrap reset vector comes from the boot ROM so the loader runs.
// RL12: The host sends FF first; the loader picks the baud rate from it.
// RL13: Bootstrap loader stores the program in RAM then jumps to it.
// RL14: The boot ROM holds 192 bytes.
// RL15: Bootstrap mode opens the protected control bits to software.
// RL16: Normal modes ignore writes to expanded-mode and special-mode select.
`timescale 1ns/1ns

module bms_core (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // Board mode straps
  input  wire logic                    mode_pin_a,
  input  wire logic                    mode_pin_b,
  // Software write of the mode control bits
  input  wire logic                    ctl_wr,
  input  wire bms_pkg::bms_mode_bits_t ctl_wdata,
  // CPU address request
  input  wire bms_pkg::bms_addr_req_t  cpu_req,
  // Mode state
  output logic                         mode_valid,
  output bms_pkg::bms_mode_bits_t      mode_bits,
  output bms_pkg::bms_mode_t           op_mode,
  output logic                         protected_wr_en,
  // Memory side
  output logic [bms_pkg::ADDR_W-1:0]   mem_addr,
  output logic                         boot_rom_hit,
  output logic [bms_pkg::DATA_W-1:0]   boot_rom_data
);
  import bms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Boot ROM contents

  logic [DATA_W-1:0] rom [ROM_BYTES];

  // Reset vector points at the loader entry, the rest is filler
  function automatic logic [DATA_W-1:0] rom_byte(input int idx);
    logic [DATA_W-1:0] b;
    b = ROM_FILL;
    if (idx == VEC_HI_IDX) begin
      b = LOADER_ENTRY[15:8];  // [RL11] [RL13]
    end else if (idx == VEC_LO_IDX) begin
      b = LOADER_ENTRY[7:0];   // [RL11] [RL13]
    end
    return b;
  endfunction

  // Fixed 192-byte table
  generate
    for (genvar i = 0; i < ROM_BYTES; i++) begin : g_rom
      assign rom[i] = rom_byte(i);  // [RL14]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Mode control bits

  logic           cap_reg;
  logic           cap_next;
  bms_mode_bits_t bits_reg;
  bms_mode_bits_t bits_next;

  always_comb begin
    cap_next  = cap_reg;
    bits_next = bits_reg;
    if (!cap_reg) begin
      cap_next                       = 1'b1;
      bits_next.expanded_mode_select = mode_pin_a;                   // [RL4]
      bits_next.special_mode_select  = ~mode_pin_b;                  // [RL6]
      bits_next.boot_rom_enable      = ~mode_pin_a & ~mode_pin_b;    // [RL10]
    end else if (ctl_wr && bits_reg.special_mode_select) begin
      bits_next.expanded_mode_select = ctl_wdata.expanded_mode_select;  // [RL8]
      bits_next.special_mode_select  = ctl_wdata.special_mode_select;   // [RL8]
      bits_next.boot_rom_enable      = ctl_wdata.boot_rom_enable
                                       & ctl_wdata.special_mode_select;  // [RL2] [RL3]
    end else if (!bits_reg.special_mode_select) begin
      bits_next.boot_rom_enable = 1'b0;  // [RL3] [RL16]
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cap_reg                       <= 1'b0;
      bits_reg.boot_rom_enable      <= BOOT_EN_RST;
      bits_reg.special_mode_select  <= SPECIAL_SEL_RST;
      bits_reg.expanded_mode_select <= EXPANDED_SEL_RST;
    end else begin
      cap_reg  <= cap_next;
      bits_reg <= bits_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  always_comb begin
    case ({bits_reg.special_mode_select, bits_reg.expanded_mode_select})  // [RL5] [RL7]
      2'b00:   op_mode = MODE_NORMAL_SINGLE;
      2'b01:   op_mode = MODE_NORMAL_EXPANDED;
      2'b10:   op_mode = MODE_SPECIAL_BOOT;
      2'b11:   op_mode = MODE_SPECIAL_TEST;
      default: op_mode = MODE_NORMAL_SINGLE;
    endcase
  end

  assign mode_valid      = cap_reg;
  assign mode_bits       = bits_reg;
  assign protected_wr_en = cap_reg & bits_reg.special_mode_select;  // [RL15]

  ////////////////////////////////////////////////////////////////////////////
  // Address remap and boot ROM read

  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic              hit_reg;
  logic              hit_next;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;
  logic [ADDR_W-1:0] rom_off;

  always_comb begin
    addr_next = cpu_req.addr;
    if (cpu_req.vector_fetch && bits_reg.special_mode_select) begin
      addr_next[VEC_FORCE_BIT] = 1'b0;  // [RL8] [RL9]
    end
    rom_off   = addr_next - ROM_BASE;
    hit_next  = bits_reg.boot_rom_enable
                && addr_next >= ROM_BASE && addr_next <= ROM_LAST;  // [RL1]
    data_next = DATA_IDLE;
    if (hit_next) begin
      data_next = rom[rom_off[7:0]];  // [RL11]
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= '0;
      hit_reg  <= 1'b0;
      data_reg <= DATA_IDLE;
    end else begin
      addr_reg <= addr_next;
      hit_reg  <= hit_next;
      data_reg <= data_next;
    end
  end

  assign mem_addr      = addr_reg;
  assign boot_rom_hit  = hit_reg;
  assign boot_rom_data = data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  rom_absent_a: assert property (  // [RL1]
    !bits_reg.boot_rom_enable |=> !boot_rom_hit && boot_rom_data == DATA_IDLE)
    else $error("boot ROM visible while disabled");

  boot_en_write_a: assert property (  // [RL2]
    cap_reg && bits_reg.special_mode_select && ctl_wr && ctl_wdata.special_mode_select
    |=> bits_reg.boot_rom_enable == $past(ctl_wdata.boot_rom_enable))
    else $error("boot ROM enable write lost in special mode");

  normal_boot_en_a: assert property (  // [RL3]
    cap_reg && !bits_reg.special_mode_select |-> !bits_reg.boot_rom_enable)
    else $error("boot ROM enable set in normal mode");

  strap_capture_a: assert property (  // [RL4] [RL6]
    !cap_reg |=> cap_reg && bits_reg.expanded_mode_select == $past(mode_pin_a)
                 && bits_reg.special_mode_select == !$past(mode_pin_b))
    else $error("mode straps not captured");

  mode_decode_a: assert property (  // [RL5] [RL7]
    (op_mode == MODE_SPECIAL_BOOT || op_mode == MODE_SPECIAL_TEST)
      == bits_reg.special_mode_select
    && (op_mode == MODE_NORMAL_EXPANDED || op_mode == MODE_SPECIAL_TEST)
      == bits_reg.expanded_mode_select)
    else $error("operating mode decode wrong");

  vec_remap_a: assert property (  // [RL9]
    cpu_req.vector_fetch |=> mem_addr[VEC_FORCE_BIT]
      == ($past(cpu_req.addr[VEC_FORCE_BIT]) && !$past(bits_reg.special_mode_select)))
    else $error("vector address bit 14 wrong");

  boot_reset_a: assert property (  // [RL10]
    !cap_reg |=> bits_reg.boot_rom_enable == ($past(!mode_pin_a) && $past(!mode_pin_b)))
    else $error("boot ROM enable reset value wrong");

  boot_vector_a: assert property (  // [RL11]
    op_mode == MODE_SPECIAL_BOOT && bits_reg.boot_rom_enable && cpu_req.vector_fetch
    && cpu_req.addr == RST_VEC_ADDR
    |=> boot_rom_hit && boot_rom_data == LOADER_ENTRY[15:8])
    else $error("bootstrap reset vector not from boot ROM");

  normal_hold_a: assert property (  // [RL16]
    cap_reg && !bits_reg.special_mode_select && ctl_wr
    |=> $stable(bits_reg.special_mode_select) && $stable(bits_reg.expanded_mode_select))
    else $error("mode select changed by write in normal mode");

  protect_a: assert property (  // [RL15]
    cap_reg ##1 op_mode == MODE_SPECIAL_BOOT |-> protected_wr_en)
    else $error("protected bits closed in bootstrap mode");

  boot_entry_c: cover property (
    !cap_reg && !mode_pin_a && !mode_pin_b ##1 op_mode == MODE_SPECIAL_BOOT);

  test_boot_en_c: cover property (
    op_mode == MODE_SPECIAL_TEST && ctl_wr && ctl_wdata.boot_rom_enable
    ##1 bits_reg.boot_rom_enable);

  boot_vec_c: cover property (
    cpu_req.vector_fetch && bits_reg.boot_rom_enable ##1 boot_rom_hit);

  leave_special_c: cover property (
    bits_reg.special_mode_select && ctl_wr && !ctl_wdata.special_mode_select
    ##1 !bits_reg.special_mode_select);

  normal_write_c: cover property (
    op_mode == MODE_NORMAL_EXPANDED && ctl_wr ##1 op_mode == MODE_NORMAL_EXPANDED);

  ////////////////////////////////////////////////////////////////////////////
  // Boot ROM map, remap and mode bit checks

  rom_present_a: assert property (  // [RL1]
    bits_reg.boot_rom_enable && !cpu_req.vector_fetch
    && cpu_req.addr >= ROM_BASE && cpu_req.addr <= ROM_LAST |=> boot_rom_hit)
    else $error("boot ROM missing while enabled");

  rom_window_a: assert property (  // [RL1] [RL14]
    boot_rom_hit |-> mem_addr >= ROM_BASE && mem_addr <= ROM_LAST)
    else $error("boot ROM hit outside its window");

  idle_data_a: assert property (  // [RL1]
    !boot_rom_hit |-> boot_rom_data == DATA_IDLE)
    else $error("data driven without a boot ROM hit");

  vec_lo_a: assert property (  // [RL11]
    boot_rom_hit && mem_addr == ROM_LAST |-> boot_rom_data == LOADER_ENTRY[7:0])
    else $error("loader entry low byte wrong");

  rom_fill_a: assert property (  // [RL14]
    boot_rom_hit && mem_addr < ROM_LAST - 16'h0001 |-> boot_rom_data == ROM_FILL)
    else $error("boot ROM filler byte wrong");

  plain_addr_a: assert property (  // [RL9]
    !cpu_req.vector_fetch |=> mem_addr == $past(cpu_req.addr))
    else $error("non-vector address altered");

  normal_vec_a: assert property (  // [RL8]
    !bits_reg.special_mode_select |=> mem_addr == $past(cpu_req.addr))
    else $error("vector address remapped in normal mode");

  special_write_a: assert property (  // [RL8]
    cap_reg && bits_reg.special_mode_select && ctl_wr
    |=> bits_reg.special_mode_select == $past(ctl_wdata.special_mode_select)
        && bits_reg.expanded_mode_select == $past(ctl_wdata.expanded_mode_select))
    else $error("mode bit write lost in special mode");

  leave_clears_a: assert property (  // [RL3]
    cap_reg && bits_reg.special_mode_select && ctl_wr && !ctl_wdata.special_mode_select
    |=> !bits_reg.boot_rom_enable)
    else $error("boot ROM enable kept after leaving special mode");

  normal_stays_a: assert property (  // [RL16]
    cap_reg && !bits_reg.special_mode_select |=> !bits_reg.special_mode_select)
    else $error("normal mode left without reset");

  strap_ignored_a: assert property (  // [RL4] [RL6]
    cap_reg && !ctl_wr |=> $stable(bits_reg))
    else $error("mode bits changed without a write");

  cap_hold_a: assert property (  // [RL4]
    cap_reg |=> cap_reg && mode_valid)
    else $error("strap capture lost before reset");

  protect_closed_a: assert property (  // [RL15]
    !bits_reg.special_mode_select |-> !protected_wr_en)
    else $error("protected bits open in normal mode");

  test_vec_a: assert property (  // [RL9]
    op_mode == MODE_SPECIAL_TEST && cpu_req.vector_fetch && cpu_req.addr == RST_VEC_ADDR
    |=> mem_addr == (RST_VEC_ADDR & ~(16'h0001 << VEC_FORCE_BIT)))
    else $error("special test reset vector not remapped");

endmodule

/* tb/bms_strap_model.sv */
// Purpose: Board straps and download host beside the boot mode select block
// Assumes: Straps held steady across the reset release
// Notes:   Host only offers its opening character; no serial port here
`timescale 1ns/1ns

module bms_strap_model (
  // Mode asked of the board
  input  wire bms_pkg::bms_mode_t mode_sel,
  // Strap pins
  output logic                    mode_pin_a,
  output logic                    mode_pin_b,
  // Host opening character
  output logic [7:0]              first_char
);
  import bms_pkg::*;
  assign mode_pin_a = mode_sel[0];
  assign mode_pin_b = ~mode_sel[1];
  assign first_char = 8'hFF;
endmodule

/* tb/bms_test.sv */
// Purpose: Self-checking bench for the boot mode select core
// Assumes: Inputs change 10 ns after the rising edge
// Notes:   Each mode is entered by a fresh reset, then random traffic
`timescale 1ns/1ns

module bms_test;
  import bms_pkg::*;
  logic            core_clk = 1'b0;
  logic            nrst = 1'b0;
  logic            ctl_wr = 1'b0;
  bms_mode_bits_t  ctl_wdata = '0;
  bms_addr_req_t   cpu_req = '0;
  bms_mode_t       strap_mode = MODE_NORMAL_SINGLE;
  bms_mode_bits_t  exp_bits;
  wire logic       mode_pin_a;
  wire logic       mode_pin_b;
  logic            mode_valid;
  bms_mode_bits_t  mode_bits;
  bms_mode_t       op_mode;
  logic            protected_wr_en;
  logic [15:0]     mem_addr;
  logic            boot_rom_hit;
  logic [7:0]      boot_rom_data;
  logic [7:0]      first_char;
  logic [15:0]     lfsr = 16'h3919;
  int              miscompares = 0;
  int              comparisons = 0;
  int              cycles = 0;

  bms_strap_model board (.mode_sel(strap_mode), .mode_pin_a(mode_pin_a),
    .mode_pin_b(mode_pin_b), .first_char(first_char));
  bms_core uut (.core_clk(core_clk), .nrst(nrst), .mode_pin_a(mode_pin_a),
    .mode_pin_b(mode_pin_b), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .cpu_req(cpu_req),
    .mode_valid(mode_valid), .mode_bits(mode_bits), .op_mode(op_mode),
    .protected_wr_en(protected_wr_en), .mem_addr(mem_addr), .boot_rom_hit(boot_rom_hit),
    .boot_rom_data(boot_rom_data));

  ////////////////////////////////////////////////////////////////////////////
  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task report_and_stop();
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function logic [15:0] next_rand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task check(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task tick();
    @(posedge core_clk);
    #10;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task check_state();
    check("mode_bits", 16'(mode_bits), 16'(exp_bits));
    check("op_mode", 16'(op_mode), 16'({exp_bits[1], exp_bits[0]}));
    check("mode_valid", 16'(mode_valid), 16'h0001);
    check("protected_wr_en", 16'(protected_wr_en), 16'(exp_bits[1]));
  endtask

  task start(bms_mode_t m);
    nrst = 1'b0;
    ctl_wr = 1'b0;
    strap_mode = m;
    repeat (16) tick();
    exp_bits = '{BOOT_EN_RST, SPECIAL_SEL_RST, EXPANDED_SEL_RST};
    check("mode_bits", 16'(mode_bits), 16'(exp_bits));
    check("mode_valid", 16'(mode_valid), 16'h0000);
    check("boot_rom_hit", 16'(boot_rom_hit), 16'h0000);
    check("first_char", 16'(first_char), 16'h00FF);
    nrst = 1'b1;
    tick();
    exp_bits = '{m == MODE_SPECIAL_BOOT, m[1], m[0]};
    check_state();
    strap_mode = bms_mode_t'(~m);
    tick();
    check_state();
  endtask

  task access(logic [15:0] a, logic vf);
    logic [15:0] ea;
    logic [15:0] idx;
    logic        hit;
    logic [7:0]  d;
    cpu_req = '{addr: a, vector_fetch: vf};
    tick();
    ea = (vf && exp_bits.special_mode_select) ? (a & 16'hBFFF) : a;
    hit = exp_bits.boot_rom_enable && ea >= ROM_BASE && ea <= ROM_LAST;
    idx = ea - ROM_BASE;
    d = !hit ? DATA_IDLE : (idx == 16'(VEC_HI_IDX)) ? LOADER_ENTRY[15:8]
      : (idx == 16'(VEC_LO_IDX)) ? LOADER_ENTRY[7:0] : ROM_FILL;
    check("mem_addr", mem_addr, ea);
    check("boot_rom_hit", 16'(boot_rom_hit), 16'(hit));
    check("boot_rom_data", 16'(boot_rom_data), 16'(d));
  endtask

  task write(bms_mode_bits_t w);
    ctl_wdata = w;
    ctl_wr = 1'b1;
    tick();
    ctl_wr = 1'b0;
    if (exp_bits.special_mode_select)
      exp_bits = '{w.boot_rom_enable & w.special_mode_select, w[1], w[0]};
    check_state();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] r;
    for (int m = 0; m < 4; m++) begin
      start(bms_mode_t'(m));
      access(RST_VEC_ADDR, 1'b1);
      access(RST_VEC_ADDR + 16'h0001, 1'b1);
      access(ROM_BASE, 1'b0);
      access(ROM_BASE - 16'h0001, 1'b0);
      write(3'b111);
      access(RST_VEC_ADDR, 1'b1);
      for (int i = 0; i < 8; i++) begin
        r = next_rand();
        write(r[2:0]);
        r = next_rand();
        access(r[14] ? {8'hBF, r[7:0]} : r, r[0]);
      end
    end
    report_and_stop();
  end
endmodule
